//--- bench/link_host_and_phy_port_tb.sv
`default_nettype none
module link_host_and_phy_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [0:5] idx; logic [0:31] wd; logic [0:31] exp;} llhp_row_t;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic sclk = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [0:5] req_idx = 6'h00;
  logic [0:31] req_wdata = 32'h0000_0000;
  logic irq = 1'b0;
  logic wrdy = 1'b0;
  logic [1:0] ctl = 2'h0;
  logic [0:7] pd = 8'h00;
  logic lvalid = 1'b0;
  logic [7:0] lword = 8'h00;
  logic req_ready, rsp_valid, irq_o, wdat_valid, half_clk, lready, lreq, h, seen;
  logic [0:31] rsp_rdata, wdat, ctrl, rd;
  logic [0:7] phy_rx;
  logic [7:0] got;
  llhp_pkg::llhp_phy_op_t phy_op;
  int miscompares = 0;
  int compares = 0;
  int n, k;
  logic [0:7] lanes [4] = '{8'hC0, 8'hF0, 8'hFF, 8'hFF};
  llhp_row_t rows [8] = '{
    '{1'b1, 6'h01, 32'hA5A5_0F0F, 32'h0000_0000},
    '{1'b0, 6'h01, 32'h0000_0000, 32'hA5A5_0F0F},
    '{1'b1, 6'h07, 32'h1122_3344, 32'h0000_0000},
    '{1'b0, 6'h07, 32'h0000_0000, 32'h1122_3344},
    '{1'b1, 6'h09, 32'hFFFF_FFFF, 32'h0000_0000},
    '{1'b0, 6'h09, 32'h0000_0000, 32'h0000_0000},
    '{1'b0, 6'h3F, 32'h0000_0000, 32'h0000_0000},
    '{1'b0, 6'h01, 32'h0000_0000, 32'hA5A5_0F0F}};
  llhp_if bus_if();
  llhp_host i_llhp_host (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus(bus_if), .req_valid_i(req_valid),
    .req_write_i(req_write), .req_idx_i(req_idx), .req_wdata_i(req_wdata), .req_ready_o(req_ready),
    .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .irq_o(irq_o));
  llhp_dev i_llhp_dev (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus(bus_if), .irq_i(irq),
    .wdat_valid_o(wdat_valid), .wdat_o(wdat), .wdat_ready_i(wrdy), .sclk_i(sclk), .phy_ctl_i(ctl),
    .phy_d_i(pd), .phy_op_o(phy_op), .phy_rx_o(phy_rx), .half_clk_o(half_clk), .lreq_valid_i(lvalid),
    .lreq_word_i(lword), .lreq_ready_o(lready), .lreq_o(lreq), .ctrl_o(ctrl));
  llhp_monitor i_llhp_monitor (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bclk(bus_if.bclk),
    .cs_n(bus_if.cs_n), .wr_n(bus_if.wr_n), .addr(bus_if.addr), .hd_oe(bus_if.hd_oe),
    .dd_oe(bus_if.dd_oe), .access_done_n(bus_if.access_done_n));
  always #2 clk_sys_i = ~clk_sys_i;
  initial begin
    #5;
    forever #32 sclk = ~sclk;
  end
  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [0:31] g, input logic [0:31] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tmo(input int c);
    if (c >= 800) begin
      miscompares++;
      $display("[FAIL] t=%0t wait=%h exp=%h", $time, c, 0);
      end_sim();
    end
  endtask
  task automatic acc(input logic w, input logic [0:5] i, input logic [0:31] d, output logic [0:31] r);
    int c;
    c = 0;
    do begin
      @(negedge clk_sys_i);
      c++;
    end while (req_ready !== 1'b1 && c < 800);
    tmo(c);
    @(posedge clk_sys_i);
    req_valid <= 1'b1;
    req_write <= w;
    req_idx <= i;
    req_wdata <= d;
    @(posedge clk_sys_i);
    req_valid <= 1'b0;
    c = 0;
    do begin
      @(negedge clk_sys_i);
      c++;
    end while (rsp_valid !== 1'b1 && c < 800);
    tmo(c);
    r = rsp_rdata;
  endtask
  task automatic do_reset();
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({25'h0, bus_if.cs_n, bus_if.access_done_n, bus_if.int_n, bus_if.dd_oe, bus_if.hd_oe, lreq, wdat_valid},
      32'h0000_0070);
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    $display("test reset done");
  endtask
  initial begin
    do_reset();
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].idx, rows[i].wd, rd);
      chk(rd, rows[i].exp);
    end
    $display("test table done");
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 6'h00, {30'h0, i[1:0]}, rd);
      @(posedge clk_sys_i);
      ctl <= i[1:0];
      pd <= 8'hB7;
      repeat (2) @(posedge sclk);
      repeat (8) @(negedge clk_sys_i);
      chk(ctrl, {30'h0, i[1:0]});
      chk({24'h0, phy_rx}, {24'h0, 8'hB7 & lanes[i]});
      chk({30'h0, phy_op}, {30'h0, i[1:0]});
    end
    h = half_clk;
    @(posedge sclk);
    repeat (8) @(negedge clk_sys_i);
    chk({31'h0, half_clk}, {31'h0, ~h});
    $display("test link pins done");
    @(posedge clk_sys_i);
    irq <= 1'b1;
    repeat (10) @(negedge clk_sys_i);
    chk({30'h0, bus_if.int_n, irq_o}, 32'h0000_0001);
    @(posedge clk_sys_i);
    irq <= 1'b0;
    repeat (10) @(negedge clk_sys_i);
    chk({30'h0, bus_if.int_n, irq_o}, 32'h0000_0002);
    $display("test interrupt done");
    chk({31'h0, lready}, 32'h0000_0001);
    @(posedge clk_sys_i);
    lvalid <= 1'b1;
    lword <= 8'hA5;
    @(posedge clk_sys_i);
    lvalid <= 1'b0;
    n = 0;
    while (lreq !== 1'b1 && n < 800) begin
      @(negedge clk_sys_i);
      n++;
    end
    tmo(n);
    for (int i = 0; i < 8; i++) begin
      @(negedge sclk);
      got[7-i] = lreq;
    end
    chk({24'h0, got}, 32'h0000_00A5);
    repeat (2) @(posedge sclk);
    repeat (4) @(negedge clk_sys_i);
    chk({30'h0, lreq, lready}, 32'h0000_0001);
    $display("test link request done");
    for (int i = 0; i < 16; i++) acc(1'b1, 6'h08, 32'hF000_0000 + i, rd);
    acc(1'b0, 6'h08, 32'h0000_0000, rd);
    chk({31'h0, rd[31]}, 32'h0000_0000);
    seen = 1'b0;
    fork
      acc(1'b1, 6'h08, 32'hF000_0010, rd);
      begin
        repeat (150) begin
          @(negedge clk_sys_i);
          if (rsp_valid === 1'b1) seen = 1'b1;
        end
        chk({31'h0, seen}, 32'h0000_0000);
        @(posedge clk_sys_i);
        wrdy <= 1'b1;
        k = 0;
        n = 0;
        while (k < 17 && n < 800) begin
          @(negedge clk_sys_i);
          n++;
          if (wdat_valid === 1'b1) begin
            chk(wdat, 32'hF000_0000 + k);
            k++;
          end
        end
        tmo(n);
      end
    join
    acc(1'b0, 6'h08, 32'h0000_0000, rd);
    chk({31'h0, rd[31]}, 32'h0000_0001);
    $display("test fifo done");
    do_reset();
    acc(1'b0, 6'h01, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    $display("test second reset done");
    end_sim();
  end
endmodule // link_host_and_phy_port_tb
`default_nettype wire

//--- bench/llhp_monitor.sv
`default_nettype none
module llhp_monitor (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_i, // Sync reset
  input wire logic bclk, // Host bus clock
  input wire logic cs_n, // Select
  input wire logic wr_n, // Direction
  input wire logic [0:7] addr, // Address
  input wire logic hd_oe, // Host drive
  input wire logic dd_oe, // Device drive
  input wire logic access_done_n // Acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  property p_addr_pad;
    !cs_n |-> addr[6:7] == 2'h0;
  endproperty
  a_addr_pad: assert property (p_addr_pad) else $error("address pad bits set");
  property p_cs_hold;
    !cs_n && $past(cs_n) == 1'b0 |-> $stable(addr) && $stable(wr_n);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("address moved in access");
  property p_ack_in_cs;
    $fell(access_done_n) |-> !cs_n;
  endproperty
  a_ack_in_cs: assert property (p_ack_in_cs) else $error("ack without select");
  property p_ack_short;
    $fell(access_done_n) |-> ##[1:8] access_done_n;
  endproperty
  a_ack_short: assert property (p_ack_short) else $error("ack too long");
  property p_ack_idle;
    cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |-> access_done_n;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack while deselected");
  property p_rd_drive;
    !access_done_n && !cs_n && wr_n |-> dd_oe;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read ack without data");
  property p_wr_quiet;
    !cs_n && !wr_n |-> !dd_oe;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("device drives on write");
  property p_wr_drive;
    !cs_n && !wr_n && !access_done_n |-> hd_oe;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write ack without data");
  property p_one_driver;
    !(dd_oe && hd_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("data contention");
  property p_bclk_rate;
    $changed(bclk) |=> $stable(bclk) [*2];
  endproperty
  a_bclk_rate: assert property (p_bclk_rate) else $error("bus clock too fast");
endmodule // llhp_monitor
`default_nettype wire

//--- rtl/llhp_dev.sv
// Operation
// - Host keeps address lines 6, 7 zero.
// - Host opens each access with select low.
// - Write-select high reads, low writes.
// - Acknowledge low marks the access complete.
// - Interrupt output low flags a pending interrupt.
// - 32-bit data, bit 0 most significant.
// - Used data lanes depend on link speed.
// - Control pair encodes four link operations.
// - Link request carries bus and register requests.
// - Host bus clock asynchronous; crossings synchronised.
// - Half-rate clock derived from the link-side system clock.
`default_nettype none
module llhp_dev (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_i, // Synchronous reset
  llhp_if.dev bus, // Host bus pins
  input wire logic irq_i, // Interrupt condition, level
  output logic wdat_valid_o, // Host write word available
  output logic [0:31] wdat_o, // Host write word
  input wire logic wdat_ready_i, // Drain a host write word
  input wire logic sclk_i, // Link-side system clock pin
  input wire logic [1:0] phy_ctl_i, // Control pair pins
  input wire logic [0:7] phy_d_i, // Link data pins
  output llhp_pkg::llhp_phy_op_t phy_op_o, // Decoded link operation
  output logic [0:7] phy_rx_o, // Link data, unused lanes zero
  output logic half_clk_o, // Half-rate link clock
  input wire logic lreq_valid_i, // Link request word offered
  input wire logic [llhp_pkg::LREQ_W-1:0] lreq_word_i, // Link request word
  output logic lreq_ready_o, // Link request word taken
  output logic lreq_o, // Serial link request pin
  output logic [0:31] ctrl_o // Control word
);
  typedef struct packed {
    logic [2:0] bclk_s;
    logic [1:0] cs_s;
    logic [1:0] wr_s;
    logic [0:7] addr_m;
    logic [0:7] addr_s;
    logic [0:31] data_m;
    logic [0:31] data_s;
    llhp_pkg::llhp_dstate_t st;
    logic done_n;
    logic [0:31] d_out;
    logic d_oe;
    logic int_n;
    logic [0:llhp_pkg::CFG_N-1][0:31] cfg;
    logic [2:0] sclk_s;
    logic [1:0] ctl_m;
    logic [1:0] ctl_s;
    logic [0:7] pd_m;
    logic [0:7] pd_s;
    logic half;
    logic [llhp_pkg::LREQ_W-1:0] lreq_sh;
    logic [llhp_pkg::LREQ_CW-1:0] lreq_cnt;
    logic lreq_busy;
    logic lreq_rdy;
    logic lreq;
    llhp_pkg::llhp_phy_op_t op;
    logic [0:7] rx;
  } llhp_dev_state_t;

  llhp_dev_state_t r;
  llhp_dev_state_t next_r;

  logic bclk_rise;
  logic sclk_rise;
  logic [0:5] idx;
  logic is_fifo;
  logic is_cfg;
  logic [llhp_pkg::CFG_IW-1:0] cfg_idx;
  logic fifo_push;
  logic fifo_in_ready;
  logic [0:31] rd_word;

  function automatic llhp_pkg::llhp_phy_op_t llhp_decode_ctl(input logic [1:0] c);
    case (c)
      2'b00: llhp_decode_ctl = llhp_pkg::LLHP_OP_IDLE;
      2'b01: llhp_decode_ctl = llhp_pkg::LLHP_OP_STATUS;
      2'b10: llhp_decode_ctl = llhp_pkg::LLHP_OP_RECEIVE;
      default: llhp_decode_ctl = llhp_pkg::LLHP_OP_GRANT;
    endcase
  endfunction

  function automatic logic [0:7] llhp_lanes(input logic [1:0] spd);
    case (spd)
      llhp_pkg::LLHP_SPD_100: llhp_lanes = llhp_pkg::LANES_100;
      llhp_pkg::LLHP_SPD_200: llhp_lanes = llhp_pkg::LANES_200;
      default: llhp_lanes = llhp_pkg::LANES_400;
    endcase
  endfunction

  // Edges are found on the second and third stages only
  assign bclk_rise = r.bclk_s[1] & ~r.bclk_s[2];
  assign sclk_rise = r.sclk_s[1] & ~r.sclk_s[2];
  assign idx = r.addr_s[0:5];
  assign is_fifo = idx == llhp_pkg::FIFO_IDX;
  assign is_cfg = idx < llhp_pkg::IDX_W'(llhp_pkg::CFG_N);
  assign cfg_idx = idx[3:5];

  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_fifo) begin
      rd_word[llhp_pkg::STAT_RDY_BIT] = fifo_in_ready;
    end else if (is_cfg) begin
      rd_word = r.cfg[cfg_idx];
    end
  end

  llhp_fifo #(
    .W(llhp_pkg::DATA_W),
    .DEPTH(llhp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_valid_i(fifo_push),
    .in_data_i(r.data_s),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(wdat_valid_o),
    .out_data_o(wdat_o),
    .out_ready_i(wdat_ready_i)
  );

  always_comb begin
    next_r = r;
    fifo_push = 1'b0;
    // Two-stage synchronisers, three stages for bclk and sclk; stage 0 feeds stage 1 only
    next_r.bclk_s = {r.bclk_s[1:0], bus.bclk};
    next_r.cs_s = {r.cs_s[0], bus.cs_n};
    next_r.wr_s = {r.wr_s[0], bus.wr_n};
    next_r.addr_m = bus.addr;
    next_r.addr_s = r.addr_m;
    next_r.data_m = bus.data;
    next_r.data_s = r.data_m;
    next_r.sclk_s = {r.sclk_s[1:0], sclk_i};
    next_r.ctl_m = phy_ctl_i;
    next_r.ctl_s = r.ctl_m;
    next_r.pd_m = phy_d_i;
    next_r.pd_s = r.pd_m;
    next_r.int_n = ~irq_i;

    case (r.st)
      llhp_pkg::LLHP_DS_IDLE, llhp_pkg::LLHP_DS_STALL: begin
        if (bclk_rise && !r.cs_s[1]) begin
          if (!r.wr_s[1]) begin
            if (is_fifo) begin
              // A full buffer holds the acknowledge back
              if (fifo_in_ready) begin
                fifo_push = 1'b1;
                next_r.done_n = 1'b0;
                next_r.st = llhp_pkg::LLHP_DS_ACK;
              end else begin
                next_r.st = llhp_pkg::LLHP_DS_STALL;
              end
            end else begin
              if (is_cfg) begin
                next_r.cfg[cfg_idx] = r.data_s;
              end
              next_r.done_n = 1'b0;
              next_r.st = llhp_pkg::LLHP_DS_ACK;
            end
          end else begin
            next_r.d_out = rd_word;
            next_r.d_oe = 1'b1;
            next_r.done_n = 1'b0;
            next_r.st = llhp_pkg::LLHP_DS_ACK;
          end
        end else if (r.cs_s[1]) begin
          next_r.st = llhp_pkg::LLHP_DS_IDLE;
        end
      end
      llhp_pkg::LLHP_DS_ACK: begin
        if (r.cs_s[1]) begin
          next_r.done_n = 1'b1;
          next_r.d_oe = 1'b0;
          next_r.st = llhp_pkg::LLHP_DS_IDLE;
        end else if (bclk_rise) begin
          next_r.done_n = 1'b1;
          next_r.st = llhp_pkg::LLHP_DS_HOLD;
        end
      end
      llhp_pkg::LLHP_DS_HOLD: begin
        if (r.cs_s[1]) begin
          next_r.d_oe = 1'b0;
          next_r.st = llhp_pkg::LLHP_DS_IDLE;
        end
      end
      default: begin
        next_r.done_n = 1'b1;
        next_r.d_oe = 1'b0;
        next_r.st = llhp_pkg::LLHP_DS_IDLE;
      end
    endcase

    // Link request word is taken between sclk edges, sent on them
    if (r.lreq_rdy && lreq_valid_i) begin
      next_r.lreq_sh = lreq_word_i;
      next_r.lreq_cnt = llhp_pkg::LREQ_CW'(llhp_pkg::LREQ_W - 1);
      next_r.lreq_busy = 1'b1;
      next_r.lreq_rdy = 1'b0;
    end
    if (sclk_rise) begin
      next_r.half = ~r.half;
      next_r.op = llhp_decode_ctl(r.ctl_s);
      next_r.rx = r.pd_s & llhp_lanes(r.cfg[llhp_pkg::CTRL_IDX][llhp_pkg::SPD_MSB:llhp_pkg::SPD_LSB]);
      if (r.lreq_busy) begin
        next_r.lreq = r.lreq_sh[llhp_pkg::LREQ_W-1];
        next_r.lreq_sh = {r.lreq_sh[llhp_pkg::LREQ_W-2:0], 1'b0};
        next_r.lreq_cnt = r.lreq_cnt - 1'b1;
        if (r.lreq_cnt == '0) begin
          next_r.lreq_busy = 1'b0;
          next_r.lreq_rdy = 1'b1;
        end
      end else begin
        next_r.lreq = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r <= '0;
      r.cs_s <= 2'h3;
      r.done_n <= 1'b1;
      // Keep tracking the link clock so release shows no false edge
      r.sclk_s <= next_r.sclk_s;
      r.int_n <= 1'b1;
      r.lreq_rdy <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign bus.access_done_n = r.done_n;
  assign bus.dd_o = r.d_out;
  assign bus.dd_oe = r.d_oe;
  assign bus.int_n = r.int_n;
  assign phy_op_o = r.op;
  assign phy_rx_o = r.rx;
  assign half_clk_o = r.half;
  assign lreq_ready_o = r.lreq_rdy;
  assign lreq_o = r.lreq;
  assign ctrl_o = r.cfg[llhp_pkg::CTRL_IDX];
endmodule // llhp_dev
`default_nettype wire

//--- rtl/llhp_fifo.sv
`default_nettype none
module llhp_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_i, // Synchronous reset
  input wire logic in_valid_i, // Write strobe
  input wire logic [W-1:0] in_data_i, // Write word
  output logic in_ready_o, // Room for a word
  output logic out_valid_o, // Word available
  output logic [W-1:0] out_data_o, // Head word
  input wire logic out_ready_i // Drain strobe
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [0:DEPTH-1][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic nempty;
  } llhp_fifo_state_t;

  llhp_fifo_state_t r;
  llhp_fifo_state_t next_r;
  logic push;
  logic pop;

  assign push = in_valid_i & ~r.full;
  assign pop = r.nempty & out_ready_i;
  assign in_ready_o = ~r.full;
  assign out_valid_o = r.nempty;
  assign out_data_o = r.mem[r.rp];

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_data_i;
      next_r.wp = r.wp + 1'b1;
    end
    if (pop) begin
      next_r.rp = r.rp + 1'b1;
    end
    next_r.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    next_r.full = next_r.cnt == (AW + 1)'(DEPTH);
    next_r.nempty = next_r.cnt != '0;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // llhp_fifo
`default_nettype wire

//--- rtl/llhp_host.sv
`default_nettype none
module llhp_host (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_i, // Synchronous reset
  llhp_if.host bus, // Host bus pins
  input wire logic req_valid_i, // Access request
  input wire logic req_write_i, // 1 write, 0 read
  input wire logic [0:5] req_idx_i, // Word index
  input wire logic [0:31] req_wdata_i, // Write word
  output logic req_ready_o, // Request taken
  output logic rsp_valid_o, // Access finished, pulse
  output logic [0:31] rsp_rdata_o, // Read word
  output logic irq_o // Device interrupt pending
);
  typedef struct packed {
    logic [llhp_pkg::DIV_W-1:0] div;
    logic bclk;
    llhp_pkg::llhp_hstate_t st;
    logic cs_n;
    logic wr_n;
    logic [0:7] addr;
    logic [0:31] hd;
    logic hd_oe;
    logic done_m;
    logic done_s;
    logic [0:31] d_m;
    logic [0:31] d_s;
    logic int_m;
    logic int_s;
    logic irq;
    logic rdy;
    logic rsp_v;
    logic [0:31] rsp_d;
  } llhp_host_state_t;

  llhp_host_state_t r;
  llhp_host_state_t next_r;
  logic tick;
  logic fall;
  logic rise;

  assign tick = r.div == llhp_pkg::DIV_W'(llhp_pkg::BCLK_HALF - 1);
  assign fall = tick & r.bclk;
  assign rise = tick & ~r.bclk;

  always_comb begin
    next_r = r;
    next_r.rsp_v = 1'b0;
    next_r.done_m = bus.access_done_n;
    next_r.done_s = r.done_m;
    next_r.d_m = bus.data;
    next_r.d_s = r.d_m;
    next_r.int_m = bus.int_n;
    next_r.int_s = r.int_m;
    next_r.irq = ~r.int_s;
    next_r.div = tick ? '0 : r.div + 1'b1;
    if (tick) begin
      next_r.bclk = ~r.bclk;
    end
    case (r.st)
      llhp_pkg::LLHP_HS_IDLE: begin
        if (r.rdy && req_valid_i) begin
          next_r.rdy = 1'b0;
          next_r.wr_n = ~req_write_i;
          next_r.addr = {req_idx_i, llhp_pkg::ADDR_PAD};
          next_r.hd = req_wdata_i;
          next_r.st = llhp_pkg::LLHP_HS_OPEN;
        end else if (r.done_s) begin
          next_r.rdy = 1'b1;
        end
      end
      llhp_pkg::LLHP_HS_OPEN: begin
        if (fall) begin
          next_r.cs_n = 1'b0;
          next_r.hd_oe = ~r.wr_n;
          next_r.st = llhp_pkg::LLHP_HS_WAIT;
        end
      end
      llhp_pkg::LLHP_HS_WAIT: begin
        if (rise && !r.done_s) begin
          next_r.rsp_d = r.wr_n ? r.d_s : 32'h0000_0000;
          next_r.st = llhp_pkg::LLHP_HS_CLOSE;
        end
      end
      llhp_pkg::LLHP_HS_CLOSE: begin
        if (!r.cs_n && fall) begin
          next_r.cs_n = 1'b1;
          next_r.hd_oe = 1'b0;
          next_r.rsp_v = 1'b1;
        end else if (r.cs_n && r.done_s) begin
          next_r.st = llhp_pkg::LLHP_HS_IDLE;
        end
      end
      default: begin
        next_r.st = llhp_pkg::LLHP_HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r <= '0;
      r.cs_n <= 1'b1;
      r.wr_n <= 1'b1;
      r.done_m <= 1'b1;
      r.done_s <= 1'b1;
      r.int_m <= 1'b1;
      r.int_s <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign bus.bclk = r.bclk;
  assign bus.cs_n = r.cs_n;
  assign bus.wr_n = r.wr_n;
  assign bus.addr = r.addr;
  assign bus.hd_o = r.hd;
  assign bus.hd_oe = r.hd_oe;
  assign req_ready_o = r.rdy;
  assign rsp_valid_o = r.rsp_v;
  assign rsp_rdata_o = r.rsp_d;
  assign irq_o = r.irq;
endmodule // llhp_host
`default_nettype wire

//--- rtl/llhp_if.sv
`default_nettype none
interface llhp_if;
  logic bclk;
  logic cs_n;
  logic wr_n;
  logic [0:7] addr;
  logic [0:31] hd_o;
  logic hd_oe;
  logic [0:31] dd_o;
  logic dd_oe;
  logic [0:31] data;
  logic access_done_n;
  logic int_n;

  // Shared data wire, resolved from the two drive enables
  assign data = dd_oe ? dd_o : (hd_oe ? hd_o : 32'h0000_0000);

  modport host (
    output bclk, cs_n, wr_n, addr, hd_o, hd_oe,
    input data, access_done_n, int_n
  );
  modport dev (
    input bclk, cs_n, wr_n, addr, data,
    output dd_o, dd_oe, access_done_n, int_n
  );
endinterface
`default_nettype wire

//--- rtl/llhp_pkg.sv
`default_nettype none
package llhp_pkg;
  // Host bus geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int CFG_N = 8;
  localparam int CFG_IW = 3;
  localparam logic [1:0] ADDR_PAD = 2'h0;
  localparam logic [IDX_W-1:0] FIFO_IDX = 6'h08;
  localparam int STAT_RDY_BIT = 31;
  localparam int CTRL_IDX = 0;
  localparam int SPD_MSB = 30;
  localparam int SPD_LSB = 31;
  localparam int FIFO_DEPTH = 16;

  // Host bus clock made by the host end from the system clock
  localparam int SYS_MHZ = 250;
  localparam int BCLK_MAX_MHZ = 50;
  localparam int BCLK_HALF = (SYS_MHZ + 2 * BCLK_MAX_MHZ - 1) / (2 * BCLK_MAX_MHZ);
  localparam int DIV_W = 2;

  // Link request stream
  localparam int LREQ_W = 8;
  localparam int LREQ_CW = 3;

  typedef enum logic [1:0] {
    LLHP_SPD_100 = 2'b00,
    LLHP_SPD_200 = 2'b01,
    LLHP_SPD_400 = 2'b10
  } llhp_speed_t;

  localparam logic [0:7] LANES_100 = 8'hC0;
  localparam logic [0:7] LANES_200 = 8'hF0;
  localparam logic [0:7] LANES_400 = 8'hFF;

  typedef enum logic [1:0] {
    LLHP_OP_IDLE = 2'b00,
    LLHP_OP_STATUS = 2'b01,
    LLHP_OP_RECEIVE = 2'b10,
    LLHP_OP_GRANT = 2'b11
  } llhp_phy_op_t;

  typedef enum logic [1:0] {
    LLHP_DS_IDLE = 2'b00,
    LLHP_DS_STALL = 2'b01,
    LLHP_DS_ACK = 2'b10,
    LLHP_DS_HOLD = 2'b11
  } llhp_dstate_t;

  typedef enum logic [1:0] {
    LLHP_HS_IDLE = 2'b00,
    LLHP_HS_OPEN = 2'b01,
    LLHP_HS_WAIT = 2'b10,
    LLHP_HS_CLOSE = 2'b11
  } llhp_hstate_t;
endpackage
`default_nettype wire
